/* File: design/iosd_defines.svh */
// iosd_defines.svh: offsets, spans and reset values for the I/O space decoder.
// assumes: included by bare name from the package and the design modules.
`ifndef IOSD_DEFINES_SVH
`define IOSD_DEFINES_SVH

// ***************************************************
// address spans
// ***************************************************
`define IOSD_IO_LAST 6'h3F
`define IOSD_BIT_LAST 6'h1F
`define IOSD_SRAM_OFS 16'h0020
`define IOSD_SRAM_LAST 16'h005F
`define IOSD_ADDR_W 16

// ***************************************************
// register offsets inside the I/O space
// ***************************************************
`define IOSD_SER_BAUD 6'h09
`define IOSD_SER_CTRL 6'h0A
`define IOSD_SER_STAT 6'h0B
`define IOSD_PD_IN 6'h10
`define IOSD_PD_DIR 6'h11
`define IOSD_PD_OUT 6'h12
`define IOSD_PC_OUT 6'h13
`define IOSD_PB_IN 6'h16
`define IOSD_PB_DIR 6'h17
`define IOSD_PB_OUT 6'h18
`define IOSD_PA_IN 6'h19
`define IOSD_PA_DIR 6'h1A
`define IOSD_PA_OUT 6'h1B
`define IOSD_WDOG_CTRL 6'h21
`define IOSD_CAP_LO 6'h24
`define IOSD_CAP_HI 6'h25
`define IOSD_CMPB_LO 6'h28
`define IOSD_CMPB_HI 6'h29
`define IOSD_CMPA_LO 6'h2A
`define IOSD_CMPA_HI 6'h2B
`define IOSD_WCNT_LO 6'h2C
`define IOSD_WCNT_HI 6'h2D
`define IOSD_WTMR_CTRL_B 6'h2E
`define IOSD_WTMR_CTRL_A 6'h2F
`define IOSD_NCNT 6'h32
`define IOSD_NTMR_CTRL 6'h33
`define IOSD_CORE_CTRL 6'h35
`define IOSD_TMR_FLAGS 6'h38
`define IOSD_TMR_MASK 6'h39
`define IOSD_GEN_FLAGS 6'h3A
`define IOSD_GEN_MASK 6'h3B
`define IOSD_SP_LO 6'h3D
`define IOSD_SP_HI 6'h3E
`define IOSD_COND_FLAGS 6'h3F

// ***************************************************
// reset values
// ***************************************************
`define IOSD_RST_BYTE 8'h00

`endif

/* File: design/iosd_pkg.sv */
// iosd_pkg: request, response and operation types of the I/O space decoder.
// assumes: the defines header is on the include path.
`include "iosd_defines.svh"

package iosd_pkg;

   // ***************************************************
   // core operations
   // ***************************************************
   typedef enum logic [2:0] {
      IOSD_OP_PORT_IN = 3'h0,
      IOSD_OP_PORT_OUT = 3'h1,
      IOSD_OP_DATA_LOAD = 3'h2,
      IOSD_OP_DATA_STORE = 3'h3,
      IOSD_OP_BIT_SET = 3'h4,
      IOSD_OP_BIT_CLEAR = 3'h5,
      IOSD_OP_BIT_TEST = 3'h6
   } iosd_op_t;

   typedef struct packed {
      logic valid;
      iosd_op_t op;
      logic [`IOSD_ADDR_W-1:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iosd_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [7:0] rdata;
      logic bit_val;
   } iosd_rsp_t;

endpackage : iosd_pkg

/* File: design/iosd_addr_map.sv */
// iosd_addr_map: turns a core request into an I/O register index.
// assumes: port ops carry a 6-bit address in the low bits, data ops a full data address.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module iosd_addr_map (
   input wire iosd_pkg::iosd_req_t req, // request from the core
   output logic hit, // request lands in the I/O space
   output logic [5:0] idx, // I/O register index
   output logic is_write, // request changes a register
   output logic is_bit // single-bit operation
);
   import iosd_pkg::*;

   logic [`IOSD_ADDR_W-1:0] sram_rel;

   assign sram_rel = req.addr - `IOSD_SRAM_OFS;
   assign is_bit = (req.op == IOSD_OP_BIT_SET) || (req.op == IOSD_OP_BIT_CLEAR) || (req.op == IOSD_OP_BIT_TEST);
   assign is_write = (req.op == IOSD_OP_PORT_OUT) || (req.op == IOSD_OP_DATA_STORE) ||
                     (req.op == IOSD_OP_BIT_SET) || (req.op == IOSD_OP_BIT_CLEAR);

   always_comb begin
      hit = 1'b0;
      idx = req.addr[5:0];
      case (req.op)
         IOSD_OP_PORT_IN, IOSD_OP_PORT_OUT: begin
            hit = req.valid; // R2
         end
         IOSD_OP_DATA_LOAD, IOSD_OP_DATA_STORE: begin
            idx = sram_rel[5:0]; // R3
            hit = req.valid && (req.addr >= `IOSD_SRAM_OFS) && (req.addr <= `IOSD_SRAM_LAST); // R3
         end
         IOSD_OP_BIT_SET, IOSD_OP_BIT_CLEAR, IOSD_OP_BIT_TEST: begin
            hit = req.valid && (req.addr[5:0] <= `IOSD_BIT_LAST); // R4 R5
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

endmodule : iosd_addr_map
`default_nettype wire

/* File: design/iosd_gpio_port.sv */
// iosd_gpio_port: output data and direction bytes of one port, with its pins.
// assumes: writes arrive as one-cycle strobes with the final byte already merged.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module iosd_gpio_port (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset, active high
   input wire logic wr_out, // write strobe, output data byte
   input wire logic wr_dir, // write strobe, direction byte
   input wire logic [7:0] wdata, // byte to store
   output logic [7:0] out_q, // output data byte, also pin drive level
   output logic [7:0] dir_q // direction byte, also pin output enable
);

   always_ff @(posedge clk) begin
      if (rst) begin
         out_q <= `IOSD_RST_BYTE;
      end else if (wr_out) begin
         out_q <= wdata; // R9
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dir_q <= `IOSD_RST_BYTE;
      end else if (wr_dir) begin
         dir_q <= wdata; // R9
      end
   end

endmodule : iosd_gpio_port
`default_nettype wire

/* File: design/iosd_decoder.sv */
// iosd_decoder: I/O register space of the 8-bit core, 64 byte-wide registers in two views.
// assumes: one request per cycle from the core, answered one cycle later from flip-flops.
//
// Notes on behaviour
// R1: port input and output instructions move a byte between a working register and the addressed I/O register.
// R2: port instructions use a 6-bit I/O address from 00 to 3F, all of which is decoded.
// R3: data-memory accesses see each I/O register at its I/O address plus 20.
// R4: bit set and bit clear work on addresses 00 to 1F and change only the chosen bit.
// R5: the skip tests on addresses 00 to 1F get the value of the chosen bit.
// R6: every general peripheral sits in the I/O space, the USB registers never do.
// R7: software writes zero to reserved bits.
// R8: software never writes an address where no register is defined.
// R9: ports A, B and D have output, direction and pin-input registers, port C only an output register at 13.
// R10: 16-bit timer, compare and capture values are split into a low byte and a high byte one address above.
// R11: pin-input registers read the pin levels and ignore writes.
// R12: reads of undefined addresses return zero and touch no peripheral.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module iosd_decoder (
   input wire logic clk, // core clock, 20 MHz
   input wire logic rst, // synchronous reset, active high
   input wire iosd_pkg::iosd_req_t req, // access from the core
   output iosd_pkg::iosd_rsp_t rsp, // answer, one cycle after the request
   input wire logic [7:0] pa_in, // port A pin levels
   output logic [7:0] pa_out, // port A pin drive level
   output logic [7:0] pa_oe, // port A pin output enable
   input wire logic [7:0] pb_in, // port B pin levels
   output logic [7:0] pb_out, // port B pin drive level
   output logic [7:0] pb_oe, // port B pin output enable
   input wire logic [7:0] pd_in, // port D pin levels
   output logic [7:0] pd_out, // port D pin drive level
   output logic [7:0] pd_oe, // port D pin output enable
   output logic [7:0] pc_out, // port C output byte
   input wire logic [15:0] capture_in, // captured 16-bit timer value
   input wire logic [7:0] ser_status_in, // serial status from the serial unit
   input wire logic [7:0] tmr_evt_set, // timer events, one-cycle pulses
   input wire logic [7:0] gen_evt_set, // general events, one-cycle pulses
   output logic [511:0] reg_image, // stored bytes, index 0 in the low byte
   output logic [63:0] wr_pulse, // register written, one cycle, aligned to rsp
   output logic [63:0] rd_pulse // defined register read, one cycle, aligned to rsp
);
   import iosd_pkg::*;

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction : bit_mask

   function automatic logic is_defined(input logic [5:0] a);
      case (a)
         `IOSD_SER_BAUD, `IOSD_SER_CTRL, `IOSD_SER_STAT,
         `IOSD_PD_IN, `IOSD_PD_DIR, `IOSD_PD_OUT, `IOSD_PC_OUT,
         `IOSD_PB_IN, `IOSD_PB_DIR, `IOSD_PB_OUT,
         `IOSD_PA_IN, `IOSD_PA_DIR, `IOSD_PA_OUT,
         `IOSD_WDOG_CTRL, `IOSD_CAP_LO, `IOSD_CAP_HI,
         `IOSD_CMPB_LO, `IOSD_CMPB_HI, `IOSD_CMPA_LO, `IOSD_CMPA_HI,
         `IOSD_WCNT_LO, `IOSD_WCNT_HI, `IOSD_WTMR_CTRL_B, `IOSD_WTMR_CTRL_A,
         `IOSD_NCNT, `IOSD_NTMR_CTRL, `IOSD_CORE_CTRL,
         `IOSD_TMR_FLAGS, `IOSD_TMR_MASK, `IOSD_GEN_FLAGS, `IOSD_GEN_MASK,
         `IOSD_SP_LO, `IOSD_SP_HI, `IOSD_COND_FLAGS: begin
            is_defined = 1'b1; // R6
         end
         default: begin
            is_defined = 1'b0;
         end
      endcase
   endfunction : is_defined

   // plain stored bytes, every defined byte that is neither a port A, B or D byte, an input nor a flag byte
   function automatic logic is_stored(input logic [5:0] a);
      case (a)
         `IOSD_SER_STAT, `IOSD_PA_IN, `IOSD_PB_IN, `IOSD_PD_IN,
         `IOSD_PA_DIR, `IOSD_PB_DIR, `IOSD_PD_DIR,
         `IOSD_PA_OUT, `IOSD_PB_OUT, `IOSD_PD_OUT,
         `IOSD_CAP_LO, `IOSD_CAP_HI, `IOSD_TMR_FLAGS, `IOSD_GEN_FLAGS: begin
            is_stored = 1'b0; // R11
         end
         default: begin
            is_stored = is_defined(a);
         end
      endcase
   endfunction : is_stored

   // hardware set wins over a software clear in the same cycle
   function automatic logic [7:0] merge_flags(input logic [7:0] cur, input logic [7:0] clr, input logic [7:0] set);
      merge_flags = (cur & ~clr) | set;
   endfunction : merge_flags

   // one-hot strobe for a register index
   function automatic logic [63:0] one_hot(input logic [5:0] a);
      one_hot = 64'h0000_0000_0000_0001 << a;
   endfunction : one_hot

   // ***************************************************
   // decode
   // ***************************************************
   logic hit;
   logic [5:0] idx;
   logic is_write;
   logic is_bit;
   logic do_write;
   logic do_read;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic [7:0] store_q [64];
   logic [7:0] tmr_flags_q;
   logic [7:0] gen_flags_q;
   logic [7:0] tmr_flags_d;
   logic [7:0] gen_flags_d;
   logic [7:0] pa_out_q;
   logic [7:0] pa_dir_q;
   logic [7:0] pb_out_q;
   logic [7:0] pb_dir_q;
   logic [7:0] pd_out_q;
   logic [7:0] pd_dir_q;
   iosd_rsp_t rsp_q;
   logic [63:0] wr_pulse_q;
   logic [63:0] rd_pulse_q;
   logic wr_pa_out;
   logic wr_pa_dir;
   logic wr_pb_out;
   logic wr_pb_dir;
   logic wr_pd_out;
   logic wr_pd_dir;
   logic wr_tmr_flags;
   logic wr_gen_flags;

   iosd_addr_map u_map (
      .req(req),
      .hit(hit),
      .idx(idx),
      .is_write(is_write),
      .is_bit(is_bit)
   );

   assign do_write = hit && is_write && is_defined(idx); // R8
   assign do_read = hit && !is_write && is_defined(idx); // R12

   // ***************************************************
   // write strobes of the bytes kept outside the store
   // ***************************************************
   assign wr_pa_out = do_write && idx == `IOSD_PA_OUT;
   assign wr_pa_dir = do_write && idx == `IOSD_PA_DIR;
   assign wr_pb_out = do_write && idx == `IOSD_PB_OUT;
   assign wr_pb_dir = do_write && idx == `IOSD_PB_DIR;
   assign wr_pd_out = do_write && idx == `IOSD_PD_OUT;
   assign wr_pd_dir = do_write && idx == `IOSD_PD_DIR;
   assign wr_tmr_flags = do_write && idx == `IOSD_TMR_FLAGS;
   assign wr_gen_flags = do_write && idx == `IOSD_GEN_FLAGS;

   // ***************************************************
   // read view
   // ***************************************************
   always_comb begin
      case (idx)
         `IOSD_PA_IN: begin
            rd_byte = pa_in; // R11
         end
         `IOSD_PB_IN: begin
            rd_byte = pb_in; // R11
         end
         `IOSD_PD_IN: begin
            rd_byte = pd_in; // R11
         end
         `IOSD_PA_DIR: begin
            rd_byte = pa_dir_q;
         end
         `IOSD_PB_DIR: begin
            rd_byte = pb_dir_q;
         end
         `IOSD_PD_DIR: begin
            rd_byte = pd_dir_q;
         end
         `IOSD_PA_OUT: begin
            rd_byte = pa_out_q;
         end
         `IOSD_PB_OUT: begin
            rd_byte = pb_out_q;
         end
         `IOSD_PD_OUT: begin
            rd_byte = pd_out_q;
         end
         `IOSD_CAP_LO: begin
            rd_byte = capture_in[7:0]; // R10
         end
         `IOSD_CAP_HI: begin
            rd_byte = capture_in[15:8]; // R10
         end
         `IOSD_SER_STAT: begin
            rd_byte = ser_status_in;
         end
         `IOSD_TMR_FLAGS: begin
            rd_byte = tmr_flags_q;
         end
         `IOSD_GEN_FLAGS: begin
            rd_byte = gen_flags_q;
         end
         default: begin
            rd_byte = is_stored(idx) ? store_q[idx] : `IOSD_RST_BYTE; // R12
         end
      endcase
   end

   // ***************************************************
   // write byte, merged for single-bit operations
   // ***************************************************
   always_comb begin
      case (req.op)
         IOSD_OP_BIT_SET: begin
            wr_byte = rd_byte | bit_mask(req.bit_sel); // R4
         end
         IOSD_OP_BIT_CLEAR: begin
            wr_byte = rd_byte & ~bit_mask(req.bit_sel); // R4
         end
         default: begin
            wr_byte = req.wdata; // R1
         end
      endcase
   end

   // ***************************************************
   // stored bytes
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 64; i++) begin
            store_q[i] <= `IOSD_RST_BYTE;
         end
      end else if (do_write && is_stored(idx)) begin
         store_q[idx] <= wr_byte; // R1 R10
      end
   end

   // ***************************************************
   // event flag bytes, written ones clear
   // ***************************************************
   always_comb begin
      tmr_flags_d = merge_flags(tmr_flags_q, wr_tmr_flags ? wr_byte : 8'h00, tmr_evt_set);
      gen_flags_d = merge_flags(gen_flags_q, wr_gen_flags ? wr_byte : 8'h00, gen_evt_set);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tmr_flags_q <= `IOSD_RST_BYTE;
      end else begin
         tmr_flags_q <= tmr_flags_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gen_flags_q <= `IOSD_RST_BYTE;
      end else begin
         gen_flags_q <= gen_flags_d;
      end
   end

   // ***************************************************
   // ports A, B and D
   // ***************************************************
   iosd_gpio_port u_port_a (
      .clk(clk),
      .rst(rst),
      .wr_out(wr_pa_out), // R9
      .wr_dir(wr_pa_dir), // R9
      .wdata(wr_byte),
      .out_q(pa_out_q),
      .dir_q(pa_dir_q)
   );

   iosd_gpio_port u_port_b (
      .clk(clk),
      .rst(rst),
      .wr_out(wr_pb_out), // R9
      .wr_dir(wr_pb_dir), // R9
      .wdata(wr_byte),
      .out_q(pb_out_q),
      .dir_q(pb_dir_q)
   );

   iosd_gpio_port u_port_d (
      .clk(clk),
      .rst(rst),
      .wr_out(wr_pd_out), // R9
      .wr_dir(wr_pd_dir), // R9
      .wdata(wr_byte),
      .out_q(pd_out_q),
      .dir_q(pd_dir_q)
   );

   assign pa_out = pa_out_q;
   assign pa_oe = pa_dir_q;
   assign pb_out = pb_out_q;
   assign pb_oe = pb_dir_q;
   assign pd_out = pd_out_q;
   assign pd_oe = pd_dir_q;
   assign pc_out = store_q[`IOSD_PC_OUT]; // R9

   // ***************************************************
   // answer and access strobes
   // ***************************************************
   // rdata stays zero on writes, misses and undefined reads
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= req.valid;
         rsp_q.hit <= hit;
         rsp_q.rdata <= (hit && !is_write && is_defined(idx)) ? rd_byte : `IOSD_RST_BYTE; // R1 R12
         rsp_q.bit_val <= hit && is_bit && is_defined(idx) && rd_byte[req.bit_sel]; // R5
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pulse_q <= '0;
      end else begin
         wr_pulse_q <= do_write ? one_hot(idx) : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_pulse_q <= '0;
      end else begin
         rd_pulse_q <= do_read ? one_hot(idx) : '0; // R12
      end
   end

   assign rsp = rsp_q;
   assign wr_pulse = wr_pulse_q;
   assign rd_pulse = rd_pulse_q;

   always_comb begin
      for (int i = 0; i < 64; i++) begin
         reg_image[i*8 +: 8] = store_q[i];
      end
   end

endmodule : iosd_decoder
`default_nettype wire

/* File: test/iosd_decoder_props.sv */
// iosd_decoder_props: port assertions for the I/O space decoder.
// assumes: bound to iosd_decoder from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module iosd_decoder_props (
   input wire logic clk, // core clock
   input wire logic rst, // sync reset
   input wire iosd_pkg::iosd_req_t req, // core request
   input wire iosd_pkg::iosd_rsp_t rsp, // answer
   input wire logic [7:0] pa_in, // port A pins
   input wire logic [7:0] pa_out, // port A output byte
   input wire logic [7:0] pc_out, // port C output byte
   input wire logic [15:0] capture_in, // capture value
   input wire logic [63:0] rd_pulse // read strobes
);
   import iosd_pkg::*;
   // ****************
   // helpers
   // ****************
   logic bit_q;
   logic [15:0] cap_q;
   logic is_data;
   logic data_miss;
   always_ff @(posedge clk) begin
      bit_q <= pa_in[req.bit_sel];
   end
   always_ff @(posedge clk) begin
      cap_q <= capture_in;
   end
   assign is_data = req.op == IOSD_OP_DATA_LOAD || req.op == IOSD_OP_DATA_STORE;
   assign data_miss = req.addr < `IOSD_SRAM_OFS || req.addr > `IOSD_SRAM_LAST;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ****************
   // properties
   // ****************
   chk_rsp_follows: assert property (req.valid |=> rsp.valid)
      else $error("no answer after request");
   chk_rsp_idle: assert property (!req.valid |=> !rsp.valid)
      else $error("answer without request");
   chk_port_write: assert property (req.valid && req.op == IOSD_OP_PORT_OUT && req.addr[5:0] == `IOSD_PA_OUT
      |=> pa_out == $past(req.wdata)) else $error("port write lost");
   chk_store_offset: assert property (req.valid && req.op == IOSD_OP_DATA_STORE && req.addr == 16'h0033
      |=> pc_out == $past(req.wdata)) else $error("data store missed port C");
   chk_data_miss: assert property (req.valid && is_data && data_miss
      |=> !rsp.hit && rsp.rdata == 8'h00) else $error("data access outside window hit");
   chk_bit_set: assert property (req.valid && req.op == IOSD_OP_BIT_SET && req.addr[5:0] == `IOSD_PC_OUT
      |=> pc_out == ($past(pc_out) | (8'h01 << $past(req.bit_sel)))) else $error("bit set wrong");
   chk_bit_clear: assert property (req.valid && req.op == IOSD_OP_BIT_CLEAR && req.addr[5:0] == `IOSD_PC_OUT
      |=> pc_out == ($past(pc_out) & ~(8'h01 << $past(req.bit_sel)))) else $error("bit clear wrong");
   chk_bit_test: assert property (req.valid && req.op == IOSD_OP_BIT_TEST && req.addr[5:0] == `IOSD_PA_IN
      |=> rsp.bit_val == bit_q) else $error("bit test wrong");
   chk_undef_read: assert property (req.valid && req.op == IOSD_OP_PORT_IN && req.addr[5:0] == 6'h00
      |=> rsp.rdata == 8'h00 && rd_pulse == 64'h0000_0000_0000_0000) else $error("undefined read not quiet");
   chk_capture_hi: assert property (req.valid && req.op == IOSD_OP_PORT_IN && req.addr[5:0] == `IOSD_CAP_HI
      |=> rsp.rdata == cap_q[15:8]) else $error("capture high byte wrong");
   chk_load_view: assert property (req.valid && req.op == IOSD_OP_DATA_LOAD && req.addr == 16'h003B
      |=> rd_pulse[27] && rsp.rdata == pa_out) else $error("data load view wrong");
endmodule : iosd_decoder_props
`default_nettype wire

/* File: test/iosd_core_model.sv */
// iosd_core_model: processor core issuing I/O accesses.
// assumes: one request at a time, answer sampled mid-cycle.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module iosd_core_model (
   input wire logic clk, // core clock
   output var iosd_pkg::iosd_req_t req, // request to decoder
   input wire iosd_pkg::iosd_rsp_t rsp // answer
);
   import iosd_pkg::*;
   // writes only to defined full-byte registers
   localparam logic [5:0] RW_TAB [12] = '{`IOSD_SER_BAUD, `IOSD_SER_CTRL, `IOSD_PD_DIR, `IOSD_PD_OUT,
      `IOSD_PC_OUT, `IOSD_PB_DIR, `IOSD_PB_OUT, `IOSD_PA_DIR, `IOSD_PA_OUT, `IOSD_CMPA_LO, `IOSD_CMPA_HI, `IOSD_SP_LO};
   iosd_rsp_t got;
   initial begin
      req = '0;
   end
   function automatic logic [5:0] rw_at(input int i);
      rw_at = RW_TAB[i];
   endfunction : rw_at
   // single access, then gap idle cycles
   task automatic acc(input iosd_op_t o, input logic [15:0] a, input logic [2:0] b, input logic [7:0] w,
      input int gap);
      @(posedge clk);
      req <= '{1'b1, o, a, b, w};
      @(posedge clk);
      req.valid <= 1'b0;
      @(negedge clk);
      got = rsp;
      repeat (gap) @(posedge clk);
   endtask : acc
   // back-to-back random traffic
   task automatic blast(input int n, inout int seed);
      int k;
      iosd_op_t o;
      logic [5:0] a;
      for (k = 0; k < n; k++) begin
         o = iosd_op_t'(3'({$random(seed)} % 7));
         a = RW_TAB[(o >= IOSD_OP_BIT_SET) ? {$random(seed)} % 9 : {$random(seed)} % 12];
         @(posedge clk);
         req <= '{1'b1, o, (o == IOSD_OP_DATA_LOAD || o == IOSD_OP_DATA_STORE) ? `IOSD_SRAM_OFS + a
            : {10'h000, a}, 3'($random(seed)), 8'($random(seed))};
      end
      @(posedge clk);
      req.valid <= 1'b0;
   endtask : blast
endmodule : iosd_core_model
`default_nettype wire

/* File: test/test_iosd_decoder.sv */
// test_iosd_decoder: self-checking bench for the I/O space decoder.
// assumes: core model drives requests, bench drives pins.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defines.svh"

module test_iosd_decoder;
   import iosd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   iosd_req_t req;
   iosd_rsp_t rsp;
   logic [7:0] pa_in = 8'h00, pb_in = 8'h00, pd_in = 8'h00, ser_st = 8'h00, tev = 8'h00, gev = 8'h00;
   logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pd_out, pd_oe, pc_out, v, e;
   logic [15:0] cap = 16'h0000;
   logic [511:0] image;
   logic [63:0] wrp, rdp;
   logic [7:0] mem [64] = '{default: 8'h00};
   logic [5:0] a;
   logic [2:0] b;
   iosd_op_t o;
   int err_count = 0, compares = 0, seed = 8780, i;
   always #25 clk = ~clk;
   iosd_core_model core (.clk(clk), .req(req), .rsp(rsp));
   iosd_decoder dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
      .pc_out(pc_out), .capture_in(cap), .ser_status_in(ser_st), .tmr_evt_set(tev), .gen_evt_set(gev),
      .reg_image(image), .wr_pulse(wrp), .rd_pulse(rdp));
   // ****************
   // helpers
   // ****************
   function automatic logic [7:0] bitop(input iosd_op_t op, input logic [7:0] old, input logic [2:0] n);
      bitop = (op == IOSD_OP_BIT_SET) ? old | (8'h01 << n) : old & ~(8'h01 << n);
   endfunction : bitop
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rdchk(input logic [5:0] ad, input logic [7:0] exp, input string what);
      core.acc(IOSD_OP_PORT_IN, {10'h000, ad}, 3'h0, 8'h00, 0);
      chk(what, exp, core.got.rdata);
   endtask : rdchk
   task automatic test_done;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      #250000;
      err_count++;
      test_done();
   end
   // ****************
   // scenarios
   // ****************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset outputs", 8'h00, {7'h00, |{image, pa_out, pa_oe, pb_out, pb_oe, pd_out, pd_oe, pc_out, rsp, wrp, rdp}});
      for (i = 0; i < 12; i++) begin
         a = core.rw_at(i);
         v = 8'($random(seed));
         core.acc(IOSD_OP_PORT_OUT, {10'h000, a}, 3'h0, v, 0);
         chk("write strobe", 8'h01, {7'h00, wrp == (64'h0000_0000_0000_0001 << a)});
         core.acc(IOSD_OP_DATA_LOAD, `IOSD_SRAM_OFS + a, 3'h0, 8'h00, 1);
         chk("data view", v, core.got.rdata);
         core.acc(IOSD_OP_DATA_STORE, `IOSD_SRAM_OFS + a, 3'h0, ~v, 0);
         rdchk(a, ~v, "port view");
         mem[a] = ~v;
      end
      chk("pa out", mem[`IOSD_PA_OUT], pa_out);
      chk("pa dir", mem[`IOSD_PA_DIR], pa_oe);
      chk("pb out", mem[`IOSD_PB_OUT], pb_out);
      chk("pb dir", mem[`IOSD_PB_DIR], pb_oe);
      chk("pd out", mem[`IOSD_PD_OUT], pd_out);
      chk("pd dir", mem[`IOSD_PD_DIR], pd_oe);
      chk("pc out", mem[`IOSD_PC_OUT], pc_out);
      chk("stored byte", mem[`IOSD_CMPA_HI], image[8*`IOSD_CMPA_HI +: 8]);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         pa_in <= 8'($random(seed));
         pb_in <= 8'($random(seed));
         pd_in <= 8'($random(seed));
         ser_st <= 8'($random(seed));
         cap <= 16'($random(seed));
         core.acc(IOSD_OP_PORT_OUT, {10'h000, `IOSD_PA_IN}, 3'h0, ~pa_in, 0);
         rdchk(`IOSD_PA_IN, pa_in, "pin a");
         rdchk(`IOSD_PB_IN, pb_in, "pin b");
         rdchk(`IOSD_PD_IN, pd_in, "pin d");
         rdchk(`IOSD_SER_STAT, ser_st, "serial status");
         rdchk(`IOSD_CAP_LO, cap[7:0], "capture low");
         rdchk(`IOSD_CAP_HI, cap[15:8], "capture high");
      end
      for (i = 0; i < 16; i++) begin
         b = 3'($random(seed));
         o = i[0] ? IOSD_OP_BIT_SET : IOSD_OP_BIT_CLEAR;
         e = bitop(o, mem[`IOSD_PA_OUT], b);
         mem[`IOSD_PA_OUT] = e;
         core.acc(o, {10'h000, `IOSD_PA_OUT}, b, 8'h00, i % 3);
         chk("bit update", e, pa_out);
         core.acc(IOSD_OP_BIT_TEST, {10'h000, `IOSD_PA_IN}, b, 8'h00, 0);
         chk("bit test", {7'h00, pa_in[b]}, {7'h00, core.got.bit_val});
      end
      core.acc(IOSD_OP_BIT_SET, 16'h0020, 3'h1, 8'h00, 0);
      chk("bit op above range", 8'h00, {7'h00, core.got.hit});
      core.acc(IOSD_OP_DATA_LOAD, 16'h001F, 3'h0, 8'h00, 0);
      chk("load below window", 8'h00, {7'h00, core.got.hit});
      core.acc(IOSD_OP_DATA_LOAD, 16'h0060, 3'h0, 8'h00, 0);
      chk("load above window", 8'h00, {7'h00, core.got.hit});
      rdchk(6'h00, 8'h00, "undefined low");
      chk("read strobe", 8'h00, {7'h00, |rdp});
      rdchk(6'h3C, 8'h00, "undefined high");
      @(posedge clk);
      tev <= 8'h81;
      gev <= 8'h24;
      @(posedge clk);
      tev <= 8'h00;
      gev <= 8'h00;
      rdchk(`IOSD_TMR_FLAGS, 8'h81, "tmr flags");
      rdchk(`IOSD_GEN_FLAGS, 8'h24, "gen flags");
      core.acc(IOSD_OP_DATA_STORE, 16'h005A, 3'h0, 8'h04, 0);
      rdchk(`IOSD_GEN_FLAGS, 8'h20, "gen clear");
      fork
         core.acc(IOSD_OP_PORT_OUT, {10'h000, `IOSD_TMR_FLAGS}, 3'h0, 8'h81, 0);
         begin
            @(posedge clk);
            tev <= 8'h01;
            @(posedge clk);
            tev <= 8'h00;
         end
      join
      rdchk(`IOSD_TMR_FLAGS, 8'h01, "set wins");
      core.blast(400, seed);
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule : test_iosd_decoder

bind iosd_decoder iosd_decoder_props props (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .pa_in(pa_in),
   .pa_out(pa_out), .pc_out(pc_out), .capture_in(capture_in), .rd_pulse(rd_pulse));
`default_nettype wire
